//--- verilog/lmsc_defs.svh
// constants of the lane mux management logic and its smbus host
`ifndef LMSC_DEFS_SVH
`define LMSC_DEFS_SVH
`define LMSC_CLK_NS 50
`define LMSC_TBUF_NS 4700
`define LMSC_THIGH_MAX_NS 50000
`define LMSC_TBUF_CYC ((`LMSC_TBUF_NS + `LMSC_CLK_NS - 1) / `LMSC_CLK_NS)
`define LMSC_THIGH_CYC (`LMSC_THIGH_MAX_NS / `LMSC_CLK_NS)
`define LMSC_SCL_QTR_NS 2500
`define LMSC_SCL_QTR_CYC (`LMSC_SCL_QTR_NS / `LMSC_CLK_NS)
`define LMSC_SLAVE_BASE 7'h50
`define LMSC_BITS_PER_BYTE 4'h8
`define LMSC_TX_LAST_BIT 4'h7
`define LMSC_BUS_RELEASED 2'h3
`define LMSC_REG_DEFAULT 8'h00
`define LMSC_REG_RESET 8'h00
`define LMSC_REG_PWDN 8'h01
`define LMSC_REG_PWDN_CTL 8'h02
`define LMSC_REG_SEL 8'h03
`define LMSC_REG_OVR 8'h08
`define LMSC_REG_SWING_L0 8'h17
`define LMSC_REG_SHAPE_L0 8'h18
`define LMSC_REG_SWING_L1 8'h25
`define LMSC_REG_SHAPE_L1 8'h26
`define LMSC_REG_SWING_L2 8'h2d
`define LMSC_REG_SHAPE_L2 8'h2e
`define LMSC_REG_SWING_L3 8'h34
`define LMSC_REG_SHAPE_L3 8'h35
`define LMSC_REG_SWING_L4 8'h3b
`define LMSC_REG_SHAPE_L4 8'h3c
`define LMSC_REG_SWING_L5 8'h42
`define LMSC_REG_SHAPE_L5 8'h43
`define LMSC_RESET_BIT 0
`define LMSC_FAN_BIT 0
`define LMSC_LANE0_PATH_SELECT_BIT 1
`define LMSC_LANE1_PATH_SELECT_BIT 2
`define LMSC_OVR_FAN_BIT 0
`define LMSC_OVR_SEL_BIT 1
`define LMSC_OVR_IDLE_BIT 4
`define LMSC_PWDN_EN_BIT 0
`define LMSC_PD_HOST0 1
`define LMSC_PD_HOST1 3
`define LMSC_PD_A0 4
`define LMSC_PD_B0 5
`define LMSC_PD_A1 6
`define LMSC_PD_B1 7
`define LMSC_SWING_HIGH_CODE 3'h7
`define LMSC_SHAPE_REQUIRED 8'h01
`define LMSC_IDLE_LOW 2'h0
`define LMSC_IDLE_FLOAT 2'h1
`define LMSC_IDLE_HIGH 2'h2
`define LMSC_HREG_CTRL 3'h0
`define LMSC_HREG_SLAVE 3'h1
`define LMSC_HREG_REG 3'h2
`define LMSC_HREG_WDATA 3'h3
`define LMSC_HREG_STATUS 3'h4
`define LMSC_CTRL_GO_BIT 0
`define LMSC_CTRL_READ_BIT 1
`define LMSC_CTRL_INIT_BIT 2
`define LMSC_INIT_COUNT 3'h6
`define LMSC_STEP_RECV 2'h3
`endif

//--- verilog/lmsc_pkg.sv
// state types of the lane mux management logic
package lmsc_pkg;
  typedef enum {D_IDLE, D_ADDR, D_ADDR_ACK, D_REG, D_REG_ACK, D_DATA, D_DATA_ACK, D_TX, D_TX_ACK, D_SKIP} lmsc_dev_state_t;
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} lmsc_host_state_t;
endpackage : lmsc_pkg

//--- verilog/lmsc_smbus_if.sv
// open-drain smbus wires between host and device
interface lmsc_smbus_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up: low while any enabled driver drives low
  assign scl = !(scl_host_oe && !scl_host_o);
  assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (input sda, output scl_host_o, output scl_host_oe, output sda_host_o, output sda_host_oe);
endinterface : lmsc_smbus_if

//--- verilog/lmsc_sync.sv
// two flip-flop synchroniser for pin inputs
module lmsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : lmsc_sync

//--- verilog/lmsc_device.sv
// lane routing, idle control and smbus register slave of the mux
// Operation
// - power-up or enable low restores register defaults
// - idle input low: outputs follow inputs
// - idle input floating: automatic idle detection
// - idle input high: force electrical idle
// - lane 0 select routes side a or b
// - lane 1 select routes side a or b
// - broadcast drives both sides from host
// - smbus access only while enable high
// - slave address base plus straps in bits 3:0
// - straps pulled down give base address
// - data stable while clock high
// - data fall, clock high: start
// - data rise, clock high: stop
// - long high lines mean bus idle
// - register write and read supported
// - host write: address, register, data, stop
// - device acknowledges each written byte low
// - host sets shape registers to one
// - per-lane swing register picks amplitude
// - read: register, repeated start, byte, nack
// - reset bit restores all registers
// - register 0x03 holds selects and broadcast
`include "lmsc_defs.svh"
module lmsc_device (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // management pins
  input wire logic MGMT_PORT_ENABLE,
  input wire logic [3:0] ADDR_STRAP,
  // lane control pins
  input wire logic LANE0_PATH_SELECT,
  input wire logic LANE1_PATH_SELECT,
  input wire logic BROADCAST_SELECT,
  input wire logic [1:0] IDLE_CONTROL_INPUT,
  // lane inputs, index is lane
  input wire logic [1:0] HOST_IN,
  input wire logic [1:0] SIDE_A_IN,
  input wire logic [1:0] SIDE_B_IN,
  input wire logic [1:0] HOST_IN_QUIET,
  input wire logic [1:0] SIDE_A_IN_QUIET,
  input wire logic [1:0] SIDE_B_IN_QUIET,
  // lane outputs and bus idle
  output logic [1:0] HOST_OUT,
  output logic [1:0] SIDE_A_OUT,
  output logic [1:0] SIDE_B_OUT,
  output logic [1:0] HOST_OUT_IDLE,
  output logic [1:0] SIDE_A_OUT_IDLE,
  output logic [1:0] SIDE_B_OUT_IDLE,
  output logic [1:0] OUTPUT_SWING_HIGH,
  output logic BUS_IDLE,
  // smbus
  lmsc_smbus_if.device SMB
);
  localparam int NPIN = 24;
  localparam logic [9:0] TBUF_CYC = 10'(`LMSC_TBUF_CYC);
  localparam logic [9:0] THIGH_CYC = 10'(`LMSC_THIGH_CYC);

  logic [NPIN-1:0] pin_q;
  logic en, scl, sda, scl_d, sda_d, pin_lane0_path_select, pin_lane1_path_select, pin_fan;
  logic [3:0] strap;
  logic [1:0] idle_mode, h_in, a_in, b_in, h_q, a_q, b_q;
  logic [7:0] regs [0:255];
  lmsc_pkg::lmsc_dev_state_t state;
  logic [3:0] cnt;
  logic [7:0] shreg, ptr;
  logic rw, wr_fire, after_stop;
  logic [9:0] hi_cnt;
  logic [1:0] lane_sel, pd_host, pd_a, pd_b;
  logic [1:0] next_host_idle, next_a_idle, next_b_idle, next_host_out;
  logic fan;
  logic [1:0] idle_eff;

  lmsc_sync #(.W(NPIN), .INIT({22'h000000, `LMSC_BUS_RELEASED})) u_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .d({MGMT_PORT_ENABLE, ADDR_STRAP, LANE0_PATH_SELECT, LANE1_PATH_SELECT, BROADCAST_SELECT,
        IDLE_CONTROL_INPUT, HOST_IN, SIDE_A_IN, SIDE_B_IN, HOST_IN_QUIET, SIDE_A_IN_QUIET,
        SIDE_B_IN_QUIET, SMB.scl, SMB.sda}),
    .q(pin_q)
  );
  assign {en, strap, pin_lane0_path_select, pin_lane1_path_select, pin_fan, idle_mode, h_in, a_in, b_in, h_q, a_q, b_q, scl, sda} = pin_q;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  wire scl_rise = scl && !scl_d;
  wire scl_fall = !scl && scl_d;
  wire start = scl && scl_d && sda_d && !sda;
  wire stop = scl && scl_d && !sda_d && sda;
  // straps rely on pad pull-downs, so open straps read as zero
  wire [6:0] slave_addr = `LMSC_SLAVE_BASE | {3'h0, strap};
  wire bus_timeout = hi_cnt >= THIGH_CYC;

  function automatic logic reg_mapped(input logic [7:0] a);
    case (a)
      `LMSC_REG_RESET, `LMSC_REG_PWDN, `LMSC_REG_PWDN_CTL, `LMSC_REG_SEL, `LMSC_REG_OVR,
      `LMSC_REG_SWING_L0, `LMSC_REG_SHAPE_L0, `LMSC_REG_SWING_L1, `LMSC_REG_SHAPE_L1,
      `LMSC_REG_SWING_L2, `LMSC_REG_SHAPE_L2, `LMSC_REG_SWING_L3, `LMSC_REG_SHAPE_L3,
      `LMSC_REG_SWING_L4, `LMSC_REG_SHAPE_L4, `LMSC_REG_SWING_L5, `LMSC_REG_SHAPE_L5: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction : reg_mapped

  function automatic logic idle_of(input logic [1:0] mode, input logic mute, input logic quiet);
    case (mode)
      `LMSC_IDLE_LOW: idle_of = mute;
      `LMSC_IDLE_HIGH: idle_of = 1'b1;
      default: idle_of = mute || quiet;
    endcase
  endfunction : idle_of

  wire soft_reset = wr_fire && ptr == `LMSC_REG_RESET && shreg[`LMSC_RESET_BIT];

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < 256; i++) regs[i] <= `LMSC_REG_DEFAULT;
    end else if (!en || soft_reset) begin
      for (int i = 0; i < 256; i++) regs[i] <= `LMSC_REG_DEFAULT;
    end else if (wr_fire && reg_mapped(ptr)) begin
      regs[ptr] <= shreg;
    end
  end

  // bus watch: free time after stop, or clock and data both high past the clock-high limit
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      // reset counts as a full free time, so bus idle does not drop at release
      hi_cnt <= TBUF_CYC;
      after_stop <= 1'b1;
      BUS_IDLE <= 1'b1;
    end else begin
      if (!(scl && sda)) begin
        hi_cnt <= '0;
      end else if (!bus_timeout) begin
        hi_cnt <= hi_cnt + 10'h001;
      end
      if (stop) begin
        after_stop <= 1'b1;
      end else if (start) begin
        after_stop <= 1'b0;
      end
      BUS_IDLE <= (after_stop && hi_cnt >= TBUF_CYC) || bus_timeout;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= lmsc_pkg::D_IDLE;
      cnt <= '0;
      shreg <= '0;
      ptr <= '0;
      rw <= 1'b0;
      wr_fire <= 1'b0;
    end else begin
      wr_fire <= 1'b0;
      if (!en) begin
        state <= lmsc_pkg::D_IDLE;
      end else if (start) begin
        state <= lmsc_pkg::D_ADDR;
        cnt <= '0;
      end else if (stop || bus_timeout) begin
        state <= lmsc_pkg::D_IDLE;
      end else begin
        case (state)
          lmsc_pkg::D_ADDR, lmsc_pkg::D_REG, lmsc_pkg::D_DATA: begin
            // sampled on the rising edge, where the line is stable
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == `LMSC_BITS_PER_BYTE) begin
              cnt <= '0;
              case (state)
                lmsc_pkg::D_ADDR: begin
                  if (shreg[7:1] == slave_addr) begin
                    rw <= shreg[0];
                    state <= lmsc_pkg::D_ADDR_ACK;
                  end else begin
                    state <= lmsc_pkg::D_SKIP;
                  end
                end
                lmsc_pkg::D_REG: begin
                  ptr <= shreg;
                  state <= lmsc_pkg::D_REG_ACK;
                end
                default: state <= lmsc_pkg::D_DATA_ACK;
              endcase
            end
          end
          lmsc_pkg::D_ADDR_ACK: begin
            if (scl_fall && rw) begin
              shreg <= reg_mapped(ptr) ? regs[ptr] : `LMSC_REG_DEFAULT;
              state <= lmsc_pkg::D_TX;
            end else if (scl_fall) begin
              state <= lmsc_pkg::D_REG;
            end
          end
          lmsc_pkg::D_REG_ACK: begin
            if (scl_fall) begin
              state <= lmsc_pkg::D_DATA;
            end
          end
          lmsc_pkg::D_DATA_ACK: begin
            if (scl_fall) begin
              wr_fire <= 1'b1;
              state <= lmsc_pkg::D_SKIP;
            end
          end
          lmsc_pkg::D_TX: begin
            if (scl_fall) begin
              shreg <= {shreg[6:0], 1'b1};
              if (cnt == `LMSC_TX_LAST_BIT) begin
                cnt <= '0;
                state <= lmsc_pkg::D_TX_ACK;
              end else begin
                cnt <= cnt + 4'h1;
              end
            end
          end
          // one byte per read: the host answer closes it either way
          lmsc_pkg::D_TX_ACK: begin
            if (scl_rise) begin
              state <= lmsc_pkg::D_SKIP;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign SMB.sda_dev_o = 1'b0;
  assign SMB.sda_dev_oe = state == lmsc_pkg::D_ADDR_ACK || state == lmsc_pkg::D_REG_ACK ||
                          state == lmsc_pkg::D_DATA_ACK || (state == lmsc_pkg::D_TX && !shreg[7]);

  // pin control unless the override register blocks it
  wire [7:0] sel_reg = regs[`LMSC_REG_SEL];
  wire [7:0] ovr_reg = regs[`LMSC_REG_OVR];
  wire [7:0] pd_reg = regs[`LMSC_REG_PWDN];
  wire pd_on = regs[`LMSC_REG_PWDN_CTL][`LMSC_PWDN_EN_BIT];
  assign lane_sel[0] = ovr_reg[`LMSC_OVR_SEL_BIT] ? sel_reg[`LMSC_LANE0_PATH_SELECT_BIT] : pin_lane0_path_select;
  assign lane_sel[1] = ovr_reg[`LMSC_OVR_SEL_BIT] ? sel_reg[`LMSC_LANE1_PATH_SELECT_BIT] : pin_lane1_path_select;
  assign fan = ovr_reg[`LMSC_OVR_FAN_BIT] ? sel_reg[`LMSC_FAN_BIT] : pin_fan;
  assign idle_eff = ovr_reg[`LMSC_OVR_IDLE_BIT] ? `LMSC_IDLE_FLOAT : idle_mode;
  assign pd_host = pd_on ? {pd_reg[`LMSC_PD_HOST1], pd_reg[`LMSC_PD_HOST0]} : 2'h0;
  assign pd_a = pd_on ? {pd_reg[`LMSC_PD_A1], pd_reg[`LMSC_PD_A0]} : 2'h0;
  assign pd_b = pd_on ? {pd_reg[`LMSC_PD_B1], pd_reg[`LMSC_PD_B0]} : 2'h0;

  always_comb begin
    for (int l = 0; l < 2; l++) begin
      next_host_out[l] = lane_sel[l] ? a_in[l] : b_in[l];
      next_host_idle[l] = idle_of(idle_eff, pd_host[l], lane_sel[l] ? a_q[l] : b_q[l]);
      next_a_idle[l] = idle_of(idle_eff, !(lane_sel[l] || fan) || pd_a[l], h_q[l]);
      next_b_idle[l] = idle_of(idle_eff, (lane_sel[l] && !fan) || pd_b[l], h_q[l]);
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      HOST_OUT <= '0;
      SIDE_A_OUT <= '0;
      SIDE_B_OUT <= '0;
      HOST_OUT_IDLE <= 2'h3;
      SIDE_A_OUT_IDLE <= 2'h3;
      SIDE_B_OUT_IDLE <= 2'h3;
      OUTPUT_SWING_HIGH <= '0;
    end else begin
      HOST_OUT <= next_host_out & ~next_host_idle;
      SIDE_A_OUT <= h_in & ~next_a_idle;
      SIDE_B_OUT <= h_in & ~next_b_idle;
      HOST_OUT_IDLE <= next_host_idle;
      SIDE_A_OUT_IDLE <= next_a_idle;
      SIDE_B_OUT_IDLE <= next_b_idle;
      OUTPUT_SWING_HIGH[0] <= regs[`LMSC_REG_SWING_L0][2:0] == `LMSC_SWING_HIGH_CODE;
      OUTPUT_SWING_HIGH[1] <= regs[`LMSC_REG_SWING_L1][2:0] == `LMSC_SWING_HIGH_CODE;
    end
  end
endmodule : lmsc_device

//--- verilog/lmsc_host.sv
// smbus host controller with a classic wishbone register slave
`include "lmsc_defs.svh"
module lmsc_host (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // smbus
  lmsc_smbus_if.host SMB
);
  localparam logic [5:0] QTR_LAST = 6'(`LMSC_SCL_QTR_CYC - 1);

  lmsc_pkg::lmsc_host_state_t state;
  logic sda;
  logic [5:0] qcnt;
  logic tick, scl_low, sda_low, rd, busy, nack;
  logic [1:0] phase, step;
  logic [8:0] tx, rx;
  logic [3:0] bitn;
  logic [6:0] slave;
  logic [7:0] reg_addr, wdata, rdata, cur_reg, cur_data;
  logic [2:0] init_left;

  lmsc_sync #(.W(1), .INIT(1'b1)) u_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .d(SMB.sda),
    .q(sda)
  );

  function automatic logic [7:0] shape_reg(input logic [2:0] n);
    case (n)
      3'h6: shape_reg = `LMSC_REG_SHAPE_L0;
      3'h5: shape_reg = `LMSC_REG_SHAPE_L1;
      3'h4: shape_reg = `LMSC_REG_SHAPE_L2;
      3'h3: shape_reg = `LMSC_REG_SHAPE_L3;
      3'h2: shape_reg = `LMSC_REG_SHAPE_L4;
      default: shape_reg = `LMSC_REG_SHAPE_L5;
    endcase
  endfunction : shape_reg

  function automatic logic [7:0] byte_of(input logic [1:0] s, input logic r, input logic [6:0] a,
                                         input logic [7:0] ra, input logic [7:0] d);
    case (s)
      2'h0: byte_of = {a, 1'b0};
      2'h1: byte_of = ra;
      2'h2: byte_of = r ? {a, 1'b1} : d;
      default: byte_of = 8'hff;
    endcase
  endfunction : byte_of

  wire wb_req = CYC_I && STB_I && !ACK_O;
  wire wb_wr = wb_req && WE_I && SEL_I[0];
  wire [2:0] wb_idx = ADR_I[4:2];
  wire go = wb_wr && wb_idx == `LMSC_HREG_CTRL && DAT_I[`LMSC_CTRL_GO_BIT] && !busy;
  wire init_go = wb_wr && wb_idx == `LMSC_HREG_CTRL && DAT_I[`LMSC_CTRL_INIT_BIT] && !busy;
  wire init_next = !busy && state == lmsc_pkg::H_IDLE && init_left != 3'h0;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ACK_O <= 1'b0;
      DAT_O <= '0;
      slave <= '0;
      reg_addr <= '0;
      wdata <= '0;
    end else begin
      ACK_O <= wb_req;
      if (wb_wr && wb_idx == `LMSC_HREG_SLAVE) begin
        slave <= DAT_I[6:0];
      end
      if (wb_wr && wb_idx == `LMSC_HREG_REG) begin
        reg_addr <= DAT_I[7:0];
      end
      if (wb_wr && wb_idx == `LMSC_HREG_WDATA) begin
        wdata <= DAT_I[7:0];
      end
      if (wb_req) begin
        case (wb_idx)
          `LMSC_HREG_SLAVE: DAT_O <= {25'h0000000, slave};
          `LMSC_HREG_REG: DAT_O <= {24'h000000, reg_addr};
          `LMSC_HREG_WDATA: DAT_O <= {24'h000000, wdata};
          `LMSC_HREG_STATUS: DAT_O <= {16'h0000, rdata, 6'h00, nack, busy || init_left != 3'h0};
          default: DAT_O <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      qcnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= qcnt == QTR_LAST;
      qcnt <= (qcnt == QTR_LAST) ? 6'h00 : qcnt + 6'h01;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= lmsc_pkg::H_IDLE;
      phase <= '0;
      step <= '0;
      tx <= '0;
      rx <= '0;
      bitn <= '0;
      rd <= 1'b0;
      busy <= 1'b0;
      nack <= 1'b0;
      rdata <= '0;
      cur_reg <= '0;
      cur_data <= '0;
      init_left <= '0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      if (init_go) begin
        init_left <= `LMSC_INIT_COUNT;
      end else if (go || init_next) begin
        state <= lmsc_pkg::H_START;
        phase <= '0;
        step <= '0;
        busy <= 1'b1;
        nack <= 1'b0;
        rd <= go && DAT_I[`LMSC_CTRL_READ_BIT];
        cur_reg <= go ? reg_addr : shape_reg(init_left);
        cur_data <= go ? wdata : `LMSC_SHAPE_REQUIRED;
        if (!go) begin
          init_left <= init_left - 3'h1;
        end
      end else if (tick && state != lmsc_pkg::H_IDLE) begin
        phase <= phase + 2'h1;
        case (state)
          lmsc_pkg::H_START: begin
            case (phase)
              2'h0: sda_low <= 1'b0;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b1;
              default: begin
                scl_low <= 1'b1;
                state <= lmsc_pkg::H_BIT;
                tx <= {byte_of(step, rd, slave, cur_reg, cur_data), 1'b1};
                bitn <= '0;
              end
            endcase
          end
          lmsc_pkg::H_BIT: begin
            case (phase)
              2'h0: sda_low <= !tx[8];
              2'h1: scl_low <= 1'b0;
              2'h2: rx <= {rx[7:0], sda};
              default: begin
                scl_low <= 1'b1;
                tx <= {tx[7:0], 1'b1};
                bitn <= bitn + 4'h1;
                if (bitn == `LMSC_BITS_PER_BYTE && step == `LMSC_STEP_RECV) begin
                  rdata <= rx[8:1];
                  state <= lmsc_pkg::H_STOP;
                end else if (bitn == `LMSC_BITS_PER_BYTE && rx[0]) begin
                  nack <= 1'b1;
                  state <= lmsc_pkg::H_STOP;
                end else if (bitn == `LMSC_BITS_PER_BYTE && step == 2'h1 && rd) begin
                  step <= 2'h2;
                  state <= lmsc_pkg::H_START;
                end else if (bitn == `LMSC_BITS_PER_BYTE && step == 2'h2 && !rd) begin
                  state <= lmsc_pkg::H_STOP;
                end else if (bitn == `LMSC_BITS_PER_BYTE) begin
                  step <= step + 2'h1;
                  tx <= {byte_of(step + 2'h1, rd, slave, cur_reg, cur_data), 1'b1};
                  bitn <= '0;
                end
              end
            endcase
          end
          lmsc_pkg::H_STOP: begin
            case (phase)
              2'h0: sda_low <= 1'b1;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b0;
              default: begin
                state <= lmsc_pkg::H_IDLE;
                busy <= 1'b0;
              end
            endcase
          end
          default: state <= lmsc_pkg::H_IDLE;
        endcase
      end
    end
  end

  assign SMB.scl_host_o = 1'b0;
  assign SMB.scl_host_oe = scl_low;
  assign SMB.sda_host_o = 1'b0;
  assign SMB.sda_host_oe = sda_low;
endmodule : lmsc_host

//--- sim/lmsc_smbus_sva.sv
// wire-level checks of the smbus link between host and device
module lmsc_smbus_sva (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // link wires
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // open drain: a driver may only pull low
  dev_pull_low_a: assert property (sda_dev_o == 1'b0) else $error("device drives sda high");
  host_pull_low_a: assert property (!scl_host_o && !sda_host_o) else $error("host drives high");
  dev_hold_high_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device moved sda while scl high");
  dev_ack_low_a: assert property ($rose(sda_dev_oe) |-> !scl) else $error("device drive began scl high");
  scl_low_min_a: assert property ($fell(scl) |=> !scl [*8]) else $error("scl low too short");
  scl_high_min_a: assert property ($rose(scl) |=> scl [*8]) else $error("scl high too short");
  start_src_a: assert property (scl && $fell(sda) |-> sda_host_oe && scl_host_oe == 1'b0)
    else $error("start not made by host");
  start_hold_a: assert property (scl && $fell(sda) |=> scl [*8]) else $error("start hold too short");
  stop_hold_a: assert property (scl && $rose(sda) |=> sda [*8]) else $error("stop not held");
endmodule : lmsc_smbus_sva

//--- sim/tb_lane_mux_smbus_config.sv
// bench for the lane mux device driven by its smbus host
module tb_lane_mux_smbus_config;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MODE_TAB = 8'h94;
  logic mclk = 1'b0, resetn = 1'b0, en = 1'b1, lane0_path_select = 1'b0, lane1_path_select = 1'b0, bc = 1'b0;
  logic cyc = 1'b0, we = 1'b0, ack, bus_idle;
  logic [3:0] strap = 4'h0;
  logic [1:0] idle = 2'h0, quiet = 2'h0, ho, sao, sbo, hi, sai, sbi, swing;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, dato, q;
  int miscompares = 0, n_tests = 0;
  lmsc_smbus_if smb_if ();
  lmsc_device lmsc_device_inst (.MCLK(mclk), .RESETN(resetn), .MGMT_PORT_ENABLE(en), .ADDR_STRAP(strap),
    .LANE0_PATH_SELECT(lane0_path_select), .LANE1_PATH_SELECT(lane1_path_select), .BROADCAST_SELECT(bc), .IDLE_CONTROL_INPUT(idle),
    .HOST_IN(2'h3), .SIDE_A_IN(2'h1), .SIDE_B_IN(2'h2), .HOST_IN_QUIET(quiet), .SIDE_A_IN_QUIET(quiet),
    .SIDE_B_IN_QUIET(quiet), .HOST_OUT(ho), .SIDE_A_OUT(sao), .SIDE_B_OUT(sbo), .HOST_OUT_IDLE(hi),
    .SIDE_A_OUT_IDLE(sai), .SIDE_B_OUT_IDLE(sbi), .OUTPUT_SWING_HIGH(swing), .BUS_IDLE(bus_idle),
    .SMB(smb_if.device));
  lmsc_host lmsc_host_inst (.MCLK(mclk), .RESETN(resetn), .CYC_I(cyc), .STB_I(cyc), .WE_I(we), .ADR_I(adr),
    .SEL_I(4'h1), .DAT_I(dat), .DAT_O(dato), .ACK_O(ack), .SMB(smb_if.host));
  lmsc_smbus_sva lmsc_smbus_sva_inst (.MCLK(mclk), .RESETN(resetn), .scl_host_o(smb_if.scl_host_o),
    .scl_host_oe(smb_if.scl_host_oe), .sda_host_o(smb_if.sda_host_o), .sda_host_oe(smb_if.sda_host_oe),
    .sda_dev_o(smb_if.sda_dev_o), .sda_dev_oe(smb_if.sda_dev_oe), .scl(smb_if.scl), .sda(smb_if.sda));
  initial begin
    forever #25 mclk = ~mclk;
  end
  task test_done;
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  task hang;
    miscompares++;
    test_done();
  endtask : hang
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // classic single cycle, request held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 9);
    if (ack !== 1'b1) hang();
    q = dato;
    cyc <= 1'b0;
    @(posedge mclk);
  endtask : wb
  // go code: 1 write, 3 read; status polled until not busy
  task smb(input logic [6:0] s, input logic [7:0] r, input logic [7:0] d, input logic [1:0] go,
           input logic nk);
    int n;
    wb(1'b1, 8'h04, {25'h0, s});
    wb(1'b1, 8'h08, {24'h0, r});
    wb(1'b1, 8'h0c, {24'h0, d});
    wb(1'b1, 8'h00, {30'h0, go});
    repeat (300) @(posedge mclk);
    if (en) check({31'h0, bus_idle}, 32'h0);
    n = 0;
    do begin
      wb(1'b0, 8'h10, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 4000);
    if (q[0] !== 1'b0) hang();
    check({31'h0, q[1]}, {31'h0, nk});
    repeat (150) @(posedge mclk);
    check({31'h0, bus_idle}, 32'h1);
  endtask : smb
  // inputs are host 11, side a 01, side b 10, so every path is told apart
  task route(input logic [1:0] s, input logic b);
    logic [1:0] ea, eb;
    ea = s | {2{b}};
    eb = ~s | {2{b}};
    repeat (6) @(posedge mclk);
    check({22'h0, ho, sao, sbo, sai, sbi}, {22'h0, (s & 2'h1) | (~s & 2'h2), ea, eb, ~ea, ~eb});
  endtask : route
  // host init run: six shape writes back to back, the last one read back
  task init_shape;
    int n;
    n = 0;
    wb(1'b1, 8'h00, 32'h4);
    do begin
      wb(1'b0, 8'h10, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 15000);
    if (q[0] !== 1'b0) hang();
    check({31'h0, q[1]}, 32'h0);
    smb(7'h51, 8'h43, 8'h00, 2'h3, 1'b0);
    check({24'h0, q[15:8]}, 32'h1);
  endtask : init_shape
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    check({31'h0, bus_idle}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      {bc, lane1_path_select, lane0_path_select} <= i[2:0];
      route(i[1:0], i[2]);
    end
    for (int i = 0; i < 4; i++) begin
      idle <= MODE_TAB[2*i +: 2];
      quiet <= {2{i < 2}};
      repeat (6) @(posedge mclk);
      check({26'h0, hi, sai, sbi}, {26'h0, {6{i[0]}}});
    end
    idle <= 2'h0;
    {bc, lane1_path_select, lane0_path_select} <= 3'h5;
    smb(7'h50, 8'h08, 8'h03, 2'h1, 1'b0);
    route(2'h0, 1'b0);
    smb(7'h50, 8'h03, 8'h04, 2'h1, 1'b0);
    route(2'h2, 1'b0);
    smb(7'h50, 8'h03, 8'h00, 2'h3, 1'b0);
    check({24'h0, q[15:8]}, 32'h4);
    smb(7'h51, 8'h17, 8'h07, 2'h1, 1'b1);
    strap <= 4'h1;
    smb(7'h51, 8'h17, 8'h07, 2'h1, 1'b0);
    check({30'h0, swing}, 32'h1);
    init_shape();
    en <= 1'b0;
    smb(7'h51, 8'h17, 8'h07, 2'h1, 1'b1);
    en <= 1'b1;
    route(2'h1, 1'b1);
    check({30'h0, swing}, 32'h0);
    smb(7'h51, 8'h08, 8'h03, 2'h1, 1'b0);
    route(2'h0, 1'b0);
    smb(7'h51, 8'h00, 8'h01, 2'h1, 1'b0);
    route(2'h1, 1'b1);
    test_done();
  end
endmodule : tb_lane_mux_smbus_config
